//--- tcr_pkg.sv
// Package with register map, field positions and shared types of the transceiver config bank
package tcr_pkg;
  localparam int          TCR_WORD_W       = 32;          // Serial word width
  localparam int          TCR_NUM_REGS     = 13;          // Registers in the bank
  localparam int          TCR_SEL_W        = 4;           // Register select bits
  // Register offsets
  localparam logic [3:0]  SYNTH_CHANNEL_WORD       = 4'h0;
  localparam logic [3:0]  OSCILLATOR_FILTER_WORD   = 4'h1;
  localparam logic [3:0]  TRANSMIT_MODULATION_WORD = 4'h2;
  localparam logic [3:0]  RECEIVE_CLOCK_WORD       = 4'h3;
  localparam logic [3:0]  DEMOD_SETUP_WORD         = 4'h4;
  localparam logic [3:0]  SYNC_PATTERN_WORD        = 4'h5;
  localparam logic [3:0]  CORRELATOR_WORD          = 4'h6;
  localparam logic [3:0]  READBACK_SELECT_WORD     = 4'h7;
  localparam logic [3:0]  POWERDOWN_TEST_WORD      = 4'h8;
  localparam logic [3:0]  GAIN_CONTROL_WORD        = 4'h9;
  localparam logic [3:0]  GAIN_CONTROL_AUX_WORD    = 4'hA;
  localparam logic [3:0]  FREQ_CORRECTION_WORD     = 4'hB;
  localparam logic [3:0]  TEST_MODE_WORD           = 4'hC;
  // Reset values
  localparam logic [31:0] GAIN_CONTROL_RESET = 32'h00B231E9;
  localparam logic [31:0] TEST_MODE_RESET    = 32'h0000000C;
  // Field positions
  localparam int DIRECTION_BIT   = 27;   // Synth word: 1 transmit
  localparam int LOW_BAND_BIT    = 28;   // Synth word: 431-478 MHz band
  localparam int MOD_SCHEME_LSB  = 4;    // Modulation word, 3 bits
  localparam int MOD_CTRL_LSB    = 7;    // Modulation control field, 3 bits
  localparam int INDEX_CNT_LSB   = 10;   // Index count field, 8 bits
  localparam int DIV_FACT_LSB    = 18;   // Divider factor field, 8 bits
  localparam int BBOS_DIV_LSB    = 4;    // Receive clock word fields
  localparam int DEMOD_DIV_LSB   = 8;
  localparam int CDR_DIV_LSB     = 12;
  localparam int SEQ_DIV_LSB     = 20;
  localparam int DEMOD_SEL_LSB   = 4;    // Demod word: 0 linear, 1 correlator
  localparam int DEMOD_MODE_LSB  = 6;    // Demod word: mode, 3 bits
  localparam int LOCK_THR_LSB    = 9;    // Demod word: lock threshold, 8 bits
  localparam int SYNC_SEL_LSB    = 23;   // Demod word: bits 25..23
  localparam int FILTER_CAL_BIT  = 19;   // Correlator word
  localparam int LNA_MODE_BIT    = 15;   // Correlator word
  localparam int FILT_DIV_LSB    = 20;   // Correlator word, 10 bits
  localparam int RB_ENABLE_BIT   = 8;    // Readback word
  localparam int RB_SEL_LSB      = 4;    // Readback word, 3 bits
  localparam int ADC_ON_BIT      = 8;    // Power-down word
  localparam int GAIN_LOW_LSB    = 4;    // Gain word, 7 bits
  localparam int GAIN_HIGH_LSB   = 11;   // Gain word, 7 bits
  localparam int GAIN_MODE_LSB   = 18;   // Gain word, 0 means automatic
  localparam int FREQ_SCALE_LSB  = 4;    // Frequency correction word, 16 bits
  // Shift exponents of the deviation step
  localparam logic [3:0] FSK_SHIFT_HI  = 4'hE;
  localparam logic [3:0] FSK_SHIFT_LO  = 4'hF;
  localparam logic [3:0] GFSK_SHIFT_HI = 4'hC;
  localparam logic [3:0] GFSK_SHIFT_LO = 4'hD;
  localparam logic [1:0] LNA_TOP_STEP  = 2'h3;   // Highest amplifier gain step
  localparam logic [3:0] SYNC_HOLD_BITS = 4'h9;  // Bits before sync indicator drops
  // Modulation schemes
  typedef enum logic [2:0] {
    TCR_FSK  = 3'h0,
    TCR_GFSK = 3'h1,
    TCR_ASK  = 3'h2,
    TCR_OOK  = 3'h3,
    TCR_GOOK = 3'h4
  } tcr_mod_e;
  // Readback selections
  typedef enum logic [2:0] {
    TCR_RB_RSSI = 3'h0,
    TCR_RB_BATT = 3'h1,
    TCR_RB_TEMP = 3'h2,
    TCR_RB_EXT  = 3'h3,
    TCR_RB_AFC  = 3'h4,
    TCR_RB_REV  = 3'h5,
    TCR_RB_FILT = 3'h6
  } tcr_rb_e;
  // Receive clock enables, one cycle pulses
  typedef struct packed {
    logic bbos;
    logic demod;
    logic cdr;
    logic seq;
    logic filt;
  } tcr_ticks_s;
endpackage

//--- tcr_config_bank.sv
// Transceiver configuration bank with serial load port, clock dividers and sync detector
`timescale 1ns/10ps
// How it works
// RULE1 - Direction bit selects transmit and antenna switch
// RULE2 - FSK step shift 14, lower band 15
// RULE3 - GFSK deviation shift 12 or 13
// RULE4 - Data rate divisor is index times factor
// RULE5 - Offset clock is crystal over divide field
// RULE6 - Demodulator clock is crystal over divide
// RULE7 - Recovery clock is demodulator clock over divide
// RULE8 - Sequencer clock is crystal over divide
// RULE9 - Modes 1,3,4,5 only with linear demod
// RULE10 - Mode 5 timeout counts sequencer ticks
// RULE11 - Sync detect on select 010 or 011
// RULE12 - Match 24-bit pattern raises sync pin
// RULE13 - Sync pin drops after nine bits
// RULE14 - Far transmitter sends pattern MSB first
// RULE15 - Writing bit 19 high starts calibration
// RULE16 - Filter clock is crystal over divide
// RULE17 - Reduced mode never picks top gain
// RULE18 - Readback validity depends on mode
// RULE19 - Frequency error valid with active demod
// RULE20 - Host keeps thresholds over 30 apart
// RULE21 - Top gain step only with mode 0
// RULE22 - Host programs correction scale value
// RULE23 - Default test word means normal operation
// RULE24 - Latch edge routes word by low bits
module tcr_config_bank
  import tcr_pkg::*;
#(
  parameter int SYNC_W = 24,                       // Sync pattern length
  parameter int DIV_W  = 12                        // Divider counter width
)(
  input  wire logic        i_clk,                  // Crystal rate clock
  input  wire logic        i_reset,                // Synchronous reset
  input  wire logic        i_sclk,                 // Serial clock pin
  input  wire logic        i_sdata,                // Serial data pin
  input  wire logic        i_sle,                  // Latch strobe pin
  input  wire logic        i_rx_bit,               // Recovered data bit
  input  wire logic        i_rx_bit_valid,         // Recovered bit strobe
  input  wire logic        i_demod_locked,         // Demodulator has locked
  input  wire logic [1:0]  i_gain_request,         // Step wanted by gain loop
  output logic             o_tx_mode,              // Transmit selected
  output logic             o_antenna_tx,           // Antenna switch to transmit
  output logic [3:0]       o_dev_shift,            // Deviation step divisor exponent
  output logic [2:0]       o_dev_exp,              // Deviation multiplier exponent
  output logic [15:0]      o_rate_divisor,         // Phase detector divisor for data rate
  output tcr_ticks_s       o_ticks,                // Derived clock enables
  output logic             o_long_run_ok,          // Long run-length modes active
  output logic             o_lock_timeout,         // Mode 5 lock timeout reached
  output logic             o_sync_found,           // Sync indicator pin
  output logic             o_filter_cal_start,     // Calibration start pulse
  output logic [1:0]       o_lna_gain,             // Applied amplifier gain step
  output logic             o_readback_valid,       // Selected readback is meaningful
  output logic [15:0]      o_freq_scale,           // Frequency correction scale
  output logic [6:0]       o_gain_low,             // Gain low threshold
  output logic [6:0]       o_gain_high,            // Gain high threshold
  output logic             o_normal_op             // Test word at default
);

  // Parameter check
  initial
  begin
    if (SYNC_W != 24 || DIV_W < 10)
      $error("tcr_config_bank: unsupported parameters");
  end

  logic [2:0]              sclk_sync;              // Serial clock synchroniser
  logic [2:0]              sdata_sync;             // Serial data synchroniser
  logic [2:0]              sle_sync;               // Latch synchroniser
  logic                    sclk_lvl;               // Filtered serial clock
  logic                    sle_lvl;                // Filtered latch
  logic                    sclk_rise;              // Serial clock edge
  logic                    sle_rise;               // Latch edge
  logic [TCR_WORD_W-1:0]   shift;                  // Incoming word
  logic [TCR_WORD_W-1:0]   words [TCR_NUM_REGS];   // Register bank
  logic [TCR_SEL_W-1:0]    sel;                    // Destination of incoming word

  // Pin synchronisers, three stages each
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sclk_sync  <= 3'h0;
      sdata_sync <= 3'h0;
      sle_sync   <= 3'h0;
    end
    else
    begin
      sclk_sync  <= {sclk_sync[1:0], i_sclk};
      sdata_sync <= {sdata_sync[1:0], i_sdata};
      sle_sync   <= {sle_sync[1:0], i_sle};
    end
  end

  // Levels change only when stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sclk_lvl <= 1'b0;
      sle_lvl  <= 1'b0;
    end
    else
    begin
      if (sclk_sync[1] == sclk_sync[2])
        sclk_lvl <= sclk_sync[2];
      if (sle_sync[1] == sle_sync[2])
        sle_lvl <= sle_sync[2];
    end
  end

  assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_lvl;
  assign sle_rise  = (sle_sync[1] == sle_sync[2]) && sle_sync[2] && !sle_lvl;
  assign sel       = shift[TCR_SEL_W-1:0];

  // Shift register, most significant bit arrives first
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      shift <= '0;
    else if (sclk_rise)
      shift <= {shift[TCR_WORD_W-2:0], sdata_sync[2]};  // [RULE24]
  end

  // Word transfer on latch edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int r = 0; r < TCR_NUM_REGS; r++)
        words[r] <= '0;
      words[GAIN_CONTROL_WORD] <= GAIN_CONTROL_RESET;
      words[TEST_MODE_WORD]    <= TEST_MODE_RESET;
    end
    else if (sle_rise && sel < TCR_SEL_W'(TCR_NUM_REGS))
      words[sel] <= shift;                               // [RULE24]
  end

  route_word_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE24]
    sle_rise && sel == SYNC_PATTERN_WORD |=> words[SYNC_PATTERN_WORD] == $past(shift))
    else $error("latched word not routed");

  // Direction and antenna
  assign o_tx_mode    = words[SYNTH_CHANNEL_WORD][DIRECTION_BIT];  // [RULE1]
  assign o_antenna_tx = o_tx_mode;                                 // [RULE1]

  dir_switch_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE1]
    o_antenna_tx == words[SYNTH_CHANNEL_WORD][DIRECTION_BIT])
    else $error("antenna switch disagrees with direction");

  logic                    low_band;               // 431-478 MHz band
  tcr_mod_e                mod_scheme;             // Modulation in use
  logic                    gauss;                  // Gaussian scheme
  assign low_band   = words[SYNTH_CHANNEL_WORD][LOW_BAND_BIT];
  assign mod_scheme = tcr_mod_e'(words[TRANSMIT_MODULATION_WORD][MOD_SCHEME_LSB +: 3]);
  assign gauss      = (mod_scheme == TCR_GFSK) || (mod_scheme == TCR_GOOK);

  // Deviation and data rate figures
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_dev_shift    <= FSK_SHIFT_HI;
      o_dev_exp      <= 3'h0;
      o_rate_divisor <= 16'h0000;
    end
    else
    begin
      if (gauss)
      begin
        o_dev_shift <= low_band ? GFSK_SHIFT_LO : GFSK_SHIFT_HI;                  // [RULE3]
        o_dev_exp   <= words[TRANSMIT_MODULATION_WORD][MOD_CTRL_LSB +: 3];        // [RULE3]
        o_rate_divisor <= words[TRANSMIT_MODULATION_WORD][INDEX_CNT_LSB +: 8]
                        * words[TRANSMIT_MODULATION_WORD][DIV_FACT_LSB +: 8];     // [RULE4]
      end
      else
      begin
        o_dev_shift    <= low_band ? FSK_SHIFT_LO : FSK_SHIFT_HI;                 // [RULE2]
        o_dev_exp      <= 3'h0;
        o_rate_divisor <= 16'h0000;
      end
    end
  end

  // Clock dividers: offset, demodulator, recovery, sequencer, filter
  localparam int NDIV = 5;
  logic [DIV_W-1:0]        div_val [NDIV];         // Divide ratios
  logic [NDIV-1:0]         div_src;                // Source enables
  logic [NDIV-1:0]         div_tick;               // Divider outputs
  assign div_val[0] = DIV_W'(words[RECEIVE_CLOCK_WORD][BBOS_DIV_LSB +: 4]);   // [RULE5]
  assign div_val[1] = DIV_W'(words[RECEIVE_CLOCK_WORD][DEMOD_DIV_LSB +: 4]);  // [RULE6]
  assign div_val[2] = DIV_W'(words[RECEIVE_CLOCK_WORD][CDR_DIV_LSB +: 8]);    // [RULE7]
  assign div_val[3] = DIV_W'(words[RECEIVE_CLOCK_WORD][SEQ_DIV_LSB +: 10]);   // [RULE8]
  assign div_val[4] = DIV_W'(words[CORRELATOR_WORD][FILT_DIV_LSB +: 10]);     // [RULE16]
  assign div_src    = {1'b1, 1'b1, div_tick[1], 1'b1, 1'b1};  // Recovery runs off demod [RULE7]

  for (genvar g = 0; g < NDIV; g++)
  begin : g_div
    logic [DIV_W-1:0] cnt;                         // Count of source enables
    // Divide the source enable by the ratio; zero or one passes it straight
    always_ff @(posedge i_clk)
    begin
      if (i_reset)
      begin
        cnt         <= '0;
        div_tick[g] <= 1'b0;
      end
      else if (div_src[g] && (div_val[g] <= DIV_W'(1) || cnt >= div_val[g] - DIV_W'(1)))
      begin
        cnt         <= '0;
        div_tick[g] <= 1'b1;
      end
      else
      begin
        if (div_src[g])
          cnt <= cnt + DIV_W'(1);
        div_tick[g] <= 1'b0;
      end
    end
  end

  assign o_ticks = '{bbos: div_tick[0], demod: div_tick[1], cdr: div_tick[2],
                     seq: div_tick[3], filt: div_tick[4]};

  cdr_slow_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE7]
    div_tick[2] |-> $past(div_tick[1]))
    else $error("recovery clock not derived from demodulator clock");

  // Demodulator modes
  logic [1:0]              demod_sel;              // 0 linear, 1 correlator
  logic [2:0]              demod_mode;             // Demodulator mode
  logic [7:0]              lock_cnt;               // Sequencer ticks while unlocked
  assign demod_sel  = words[DEMOD_SETUP_WORD][DEMOD_SEL_LSB +: 2];
  assign demod_mode = words[DEMOD_SETUP_WORD][DEMOD_MODE_LSB +: 3];
  assign o_long_run_ok = (demod_sel == 2'h0) && (demod_mode == 3'h1 || demod_mode == 3'h3 ||
                          demod_mode == 3'h4 || demod_mode == 3'h5);           // [RULE9]

  // Mode 5 lock timeout in sequencer clocks
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      lock_cnt <= 8'h00;
    else if (!o_long_run_ok || demod_mode != 3'h5 || o_tx_mode || i_demod_locked)
      lock_cnt <= 8'h00;
    else if (div_tick[3] && !o_lock_timeout)
      lock_cnt <= lock_cnt + 8'h01;                                            // [RULE10]
  end

  assign o_lock_timeout = (demod_mode == 3'h5) && (lock_cnt != 8'h00) &&
                          (lock_cnt >= words[DEMOD_SETUP_WORD][LOCK_THR_LSB +: 8]);  // [RULE10]

  // Sync pattern detector
  logic                    sync_on;                // Detection selected
  logic [SYNC_W-1:0]       rx_hist;                // Last received bits
  logic [SYNC_W-1:0]       next_hist;              // History with new bit
  logic [3:0]              sync_bits;              // Bits since indicator rose
  assign sync_on   = words[DEMOD_SETUP_WORD][SYNC_SEL_LSB +: 3] == 3'h2 ||
                     words[DEMOD_SETUP_WORD][SYNC_SEL_LSB +: 3] == 3'h3;       // [RULE11]
  assign next_hist = {rx_hist[SYNC_W-2:0], i_rx_bit};  // Oldest bit is MSB [RULE14]

  // Bit history
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      rx_hist <= '0;
    else if (i_rx_bit_valid)
      rx_hist <= next_hist;
  end

  // Indicator raise on match and drop after nine bits
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_sync_found <= 1'b0;
      sync_bits    <= 4'h0;
    end
    else if (!sync_on || o_tx_mode)
    begin
      o_sync_found <= 1'b0;
      sync_bits    <= 4'h0;
    end
    else if (i_rx_bit_valid)
    begin
      if (o_sync_found)
      begin
        if (sync_bits == SYNC_HOLD_BITS - 4'h1)
        begin
          o_sync_found <= 1'b0;                                               // [RULE13]
          sync_bits    <= 4'h0;
        end
        else
          sync_bits <= sync_bits + 4'h1;
      end
      else if (next_hist == words[SYNC_PATTERN_WORD][TCR_WORD_W-1 -: SYNC_W])
        o_sync_found <= 1'b1;                                                 // [RULE12]
    end
  end

  sync_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE13]
    o_sync_found |-> sync_bits < SYNC_HOLD_BITS)
    else $error("sync indicator held too long");
  sync_rx_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE12]
    $rose(o_sync_found) |-> $past(!o_tx_mode && sync_on && i_rx_bit_valid))
    else $error("sync indicator rose without match in receive");

  // Calibration start pulse on correlator word writes with bit 19 high
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_filter_cal_start <= 1'b0;
    else
      o_filter_cal_start <= sle_rise && sel == CORRELATOR_WORD && shift[FILTER_CAL_BIT];  // [RULE15]
  end

  cal_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE15]
    sle_rise && sel == CORRELATOR_WORD && shift[FILTER_CAL_BIT] |=> o_filter_cal_start ##1 !o_filter_cal_start)
    else $error("calibration start missing");

  // Amplifier gain step with reduced mode cap
  logic                    lna_reduced;            // Reduced gain mode
  assign lna_reduced = words[CORRELATOR_WORD][LNA_MODE_BIT];
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_lna_gain <= 2'h0;
    else if (lna_reduced && i_gain_request == LNA_TOP_STEP)
      o_lna_gain <= LNA_TOP_STEP - 2'h1;                                      // [RULE17] [RULE21]
    else
      o_lna_gain <= i_gain_request;
  end

  gain_cap_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE17]
    $past(lna_reduced) |-> o_lna_gain != LNA_TOP_STEP)
    else $error("top gain selected in reduced mode");
  gain_top_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE21]
    !lna_reduced && i_gain_request == LNA_TOP_STEP |=> o_lna_gain == LNA_TOP_STEP)
    else $error("top gain withheld in normal mode");

  // Readback validity
  tcr_rb_e                 rb_sel;                 // Selected readback
  logic                    agc_auto;               // Gain loop enabled
  logic                    adc_on;                 // Converter powered
  logic                    meas_ok;                // Converter readings usable
  assign rb_sel   = tcr_rb_e'(words[READBACK_SELECT_WORD][RB_SEL_LSB +: 3]);
  assign agc_auto = words[GAIN_CONTROL_WORD][GAIN_MODE_LSB +: 2] == 2'h0;
  assign adc_on   = words[POWERDOWN_TEST_WORD][ADC_ON_BIT];
  assign meas_ok  = o_tx_mode ? adc_on : !agc_auto;                          // [RULE18]

  always_comb
  begin
    o_readback_valid = 1'b0;
    if (words[READBACK_SELECT_WORD][RB_ENABLE_BIT])
    begin
      case (rb_sel)
        TCR_RB_RSSI: o_readback_valid = !o_tx_mode;                           // [RULE18]
        TCR_RB_BATT,
        TCR_RB_TEMP,
        TCR_RB_EXT:  o_readback_valid = meas_ok;                              // [RULE18]
        TCR_RB_AFC:  o_readback_valid = !o_tx_mode && demod_sel <= 2'h1;      // [RULE19]
        TCR_RB_REV,
        TCR_RB_FILT: o_readback_valid = 1'b1;
        default:     o_readback_valid = 1'b0;
      endcase
    end
  end

  rssi_rx_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE18]
    o_readback_valid && rb_sel == TCR_RB_RSSI |-> !o_tx_mode)
    else $error("signal strength valid outside receive");
  afc_valid_a: assert property (@(posedge i_clk) disable iff (i_reset)  // [RULE19]
    o_readback_valid && rb_sel == TCR_RB_AFC |-> !o_tx_mode && demod_sel < 2'h2)
    else $error("frequency error valid without active demodulator");

  // Thresholds, correction scale and test status
  assign o_gain_low   = words[GAIN_CONTROL_WORD][GAIN_LOW_LSB +: 7];          // [RULE20]
  assign o_gain_high  = words[GAIN_CONTROL_WORD][GAIN_HIGH_LSB +: 7];         // [RULE20]
  assign o_freq_scale = words[FREQ_CORRECTION_WORD][FREQ_SCALE_LSB +: 16];    // [RULE22]
  assign o_normal_op  = words[TEST_MODE_WORD] == TEST_MODE_RESET;             // [RULE23]

  normal_reset_a: assert property (@(posedge i_clk)  // [RULE23]
    $past(i_reset) |-> o_normal_op && o_gain_low == 7'h1E && o_gain_high == 7'h46)
    else $error("defaults not restored by reset");

endmodule

//--- tcr_host_model.sv
// Host model that loads words through the three-wire serial port
`timescale 1ns/10ps
module tcr_host_model (
  input  wire logic i_clk,   // Bench clock
  output logic      o_sclk,  // Serial clock pin
  output logic      o_sdata, // Serial data pin
  output logic      o_sle    // Latch strobe pin
);
  initial {o_sclk, o_sdata, o_sle} = 3'h0;
  // Five cycles a level keeps every pin well past the synchroniser depth
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      o_sdata <= w[i];
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    o_sdata <= ~w[0];                   // Released data stops showing the last bit
    repeat (5) @(posedge i_clk);
    o_sle <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_sle <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

//--- test_transceiver_config_registers.sv
// Self-checking bench for the transceiver configuration bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_transceiver_config_registers;
  import tcr_pkg::*;
  logic i_clk, i_reset, i_sclk, i_sdata, i_sle, i_rx_bit, i_rx_bit_valid, i_demod_locked;
  logic [1:0] i_gain_request, o_lna_gain;
  logic o_tx_mode, o_antenna_tx, o_long_run_ok, o_lock_timeout, o_sync_found, o_filter_cal_start;
  logic o_readback_valid, o_normal_op;
  logic [3:0] o_dev_shift;
  logic [2:0] o_dev_exp;
  logic [15:0] o_rate_divisor, o_freq_scale, seed, r;
  logic [6:0] o_gain_low, o_gain_high;
  tcr_ticks_s o_ticks;
  int err_count, checked, cal_n, n[5];
  bit cnt_en;
  tcr_config_bank u_tcr_config_bank (.i_clk, .i_reset, .i_sclk, .i_sdata, .i_sle, .i_rx_bit, .i_rx_bit_valid,
    .i_demod_locked, .i_gain_request, .o_tx_mode, .o_antenna_tx, .o_dev_shift, .o_dev_exp, .o_rate_divisor,
    .o_ticks, .o_long_run_ok, .o_lock_timeout, .o_sync_found, .o_filter_cal_start, .o_lna_gain,
    .o_readback_valid, .o_freq_scale, .o_gain_low, .o_gain_high, .o_normal_op);
  tcr_host_model u_tcr_host_model (.i_clk(i_clk), .o_sclk(i_sclk), .o_sdata(i_sdata), .o_sle(i_sle));
  // Sixteen-bit shift register for repeatable values
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Modes that allow long run lengths with the linear demodulator
  function automatic logic exp_long(input logic [2:0] m);
    return m inside {3'h1, 3'h3, 3'h4, 3'h5};
  endfunction
  // Reduced amplifier mode caps the top step
  function automatic logic [1:0] exp_gain(input logic [1:0] q, input logic lna);
    return (lna && q == LNA_TOP_STEP) ? 2'h2 : q;
  endfunction
  task automatic wr(input logic [31:0] w);
    u_tcr_host_model.send_word(w);
    #1;
  endtask
  // One received bit with its one-cycle strobe
  task automatic rx(input logic b);
    @(posedge i_clk);
    i_rx_bit <= b;
    i_rx_bit_valid <= 1'b1;
    @(posedge i_clk);
    i_rx_bit_valid <= 1'b0;
    #1;
  endtask
  task automatic gain_walk(input logic lna);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clk);
      i_gain_request <= 2'(k);
      repeat (2) @(posedge i_clk);
      #1;
      `CHK("lna_gain", exp_gain(2'(k), lna), o_lna_gain)
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Tick and calibration pulse counters, sampled mid-cycle where outputs have settled
  always @(negedge i_clk)
  begin
    if (o_filter_cal_start === 1'b1) cal_n++;
    if (cnt_en) foreach (n[i]) n[i] += int'(o_ticks[4 - i]);
  end
  initial
  begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    end_of_test;
  end
  initial
  begin
    {i_reset, i_demod_locked} = 2'h3;
    {i_rx_bit, i_rx_bit_valid, i_gain_request} = 4'h0;
    seed = 16'hFA34;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK("normal_op", 1'b1, o_normal_op)
    `CHK("dev_shift", FSK_SHIFT_HI, o_dev_shift)
    `CHK("gain_low", 7'h1E, o_gain_low)
    `CHK("gain_high", 7'h46, o_gain_high)
    wr(32'h08000000);
    `CHK("antenna_tx", 1'b1, o_antenna_tx)
    wr(32'h18000000);
    `CHK("dev_shift", FSK_SHIFT_LO, o_dev_shift)
    wr(32'h00000000);
    `CHK("tx_mode", 1'b0, o_tx_mode)
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      wr({6'h00, seed[7:0], r[7:0], r[10:8], 3'h1, 4'h2});
      `CHK("dev_exp", r[10:8], o_dev_exp)
      `CHK("dev_shift", GFSK_SHIFT_HI, o_dev_shift)
      `CHK("rate_div", {8'h00, r[7:0]} * {8'h00, seed[7:0]}, o_rate_divisor)
      wr({12'h000, r, 4'hB});
      `CHK("freq_scale", r, o_freq_scale)
    end
    wr(32'h0000001C);
    `CHK("normal_op", 1'b0, o_normal_op)
    wr(32'h0000000C);
    wr(32'hFFFFFFFD);
    `CHK("ignored", 1'b1, o_normal_op)
    for (int m = 0; m < 8; m++)
    begin
      wr({23'h000000, 3'(m), 2'h0, 4'h4});
      `CHK("long_run", exp_long(3'(m)), o_long_run_ok)
    end
    cal_n = 0;
    wr(32'h00888006);
    gain_walk(1'b1);
    wr(32'h00800006);
    `CHK("cal_pulses", 1, cal_n)
    gain_walk(1'b0);
    wr(32'h00A05243);
    repeat (100) @(posedge i_clk);
    #1;
    n = '{0, 0, 0, 0, 0};
    cnt_en = 1'b1;
    repeat (200) @(posedge i_clk);
    #1;
    cnt_en = 1'b0;
    `CHK("bbos_ticks", 50, n[0])
    `CHK("demod_ticks", 100, n[1])
    `CHK("cdr_ticks", 20, n[2])
    `CHK("seq_ticks", 20, n[3])
    `CHK("filt_ticks", 25, n[4])
    wr(32'h00000107);
    `CHK("rssi_valid", 1'b1, o_readback_valid)
    wr(32'h08000000);
    `CHK("rssi_valid", 1'b0, o_readback_valid)
    wr(32'h00000000);
    // Mode 5, linear, threshold 4: four sequencer ticks of ten cycles while unlocked
    wr(32'h00000944);
    @(posedge i_clk);
    i_demod_locked <= 1'b0;
    repeat (25) @(posedge i_clk);
    #1;
    `CHK("lock_early", 1'b0, o_lock_timeout)
    repeat (20) @(posedge i_clk);
    #1;
    `CHK("lock_timeout", 1'b1, o_lock_timeout)
    @(posedge i_clk);
    i_demod_locked <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("lock_clear", 1'b0, o_lock_timeout)
    wr(32'h12345605);
    wr(32'h01000004);
    for (int b = 31; b >= 0; b--) rx(1'(32'h00123456 >> b));
    `CHK("sync_found", 1'b1, o_sync_found)
    for (int k = 1; k <= 9; k++)
    begin
      seed = lfsr(seed);
      rx(seed[0]);
      if (k >= 8) `CHK("sync_hold", k == 8, o_sync_found)
    end
    end_of_test;
  end
endmodule
